// file: src/spi_master_slave_port.sv
// Byte-wide serial peripheral port, master or slave, with control and status as plain ports
//
// Operation
// (RL1) Port works only when enabled and its power gate bit is zero.
// (RL2) Master: data write starts clock generator and shifts eight bits out.
// (RL3) Master: after one byte clock stops, flag sets; interrupt if enabled.
// (RL4) Master never drives select automatically; software handles it.
// (RL5) Slave with select high idles, MISO off; loads allowed, no shifting.
// (RL6) Slave: full byte received sets flag; interrupt if enabled.
// (RL7) Master to slave on MOSI, slave to master on MISO, registers exchanged.
// (RL8) Transmit has only the shift register; receive has a holding buffer.
// (RL9) Software reads each byte before the next one completes, else lost.
// (RL10) External master keeps clock high and low phases over two cycles.
// (RL11) Enabled port overrides pin directions per role; others user defined.
// (RL12) Slave: select is input; while low, MISO drives if user enabled it.
// (RL13) Slave: select high resets bit counter and drops partial bits.
// (RL14) Master with select as output: plain general output, no effect.
// (RL15) Master with select as input: low clears master bit, becomes slave.
// (RL16) That select-low event also sets the transfer complete flag.
// (RL17) External circuitry holds select high to keep master operation.
// (RL18) Software checks master bit after interrupts and sets it again.
// (RL19) Last received byte stays in the receive buffer for reading.
// (RL20) Slave accepts new transmit data before the received byte is read.
// (RL21) Master lowers slave select to begin and raises it after packets.
// (RL22) Data write during a transfer sets the write collision flag.
// (RL23) Status read with flag set, then data access, clears both flags.
// (RL24) Master clock is core clock over 4..128, halved with double speed.
// (RL25) Polarity and phase pick four modes; setup and sample opposite edges.
// (RL26) Interrupt stays asserted while flag and interrupt enable are set.
`include "spi_port_defs.svh"

module spi_master_slave_port (
	input  wire logic                 core_clk,              // Core clock, 250 MHz
	input  wire logic                 rst,                   // Asynchronous reset, active high
	// Control
	input  wire logic                 serialPortPowerGate,   // High keeps the port powered down
	input  wire logic                 portEnable,            // Port enable
	input  wire logic                 portInterruptEnable,   // Interrupt enable
	input  wire logic                 dataOrderLsbFirst,     // High sends least significant bit first
	input  wire logic                 masterSelectSet,       // Pulse: select master role
	input  wire logic                 masterSelectClear,     // Pulse: select slave role
	input  wire logic                 clockPolarity,         // High: serial clock idles high
	input  wire logic                 clockPhase,            // High: sample on trailing edge
	input  wire logic                 rateSelectHigh,        // Rate select, upper bit
	input  wire logic                 rateSelectLow,         // Rate select, lower bit
	input  wire logic                 doubleSpeedBit,        // Doubles the master clock rate
	input  wire logic                 interruptAck,          // Pulse: interrupt vector entered
	// Data and status access
	input  wire logic                 dataWrite,             // Pulse: write to data register
	input  wire spi_port_pkg::byte_type dataWdata,           // Data written
	input  wire logic                 dataRead,              // Pulse: read of data register
	output      spi_port_pkg::byte_type dataRdata,           // Receive buffer
	input  wire logic                 statusRead,            // Pulse: read of status register
	output      logic                 transferCompleteFlag,  // Transfer complete flag
	output      logic                 writeCollisionFlag,    // Write collision flag
	output      logic                 masterSelectBit,       // Current role, high for master
	output      logic                 transferBusy,          // Byte in progress
	output      logic                 irq,                   // Interrupt request, active high
	// User pin directions, high for output
	input  wire logic                 dirSck,                // Serial clock pin direction
	input  wire logic                 dirMosi,               // MOSI pin direction
	input  wire logic                 dirMiso,               // MISO pin direction
	input  wire logic                 dirSs,                 // Select pin direction
	input  wire logic                 ssOutValue,            // Select level when used as output
	// Pins
	input  wire logic                 sckIn,                 // Serial clock pin level
	output      logic                 sckOut,                // Serial clock drive value
	output      logic                 sckOe,                 // Serial clock output enable
	input  wire logic                 mosiIn,                // MOSI pin level
	output      logic                 mosiOut,               // MOSI drive value
	output      logic                 mosiOe,                // MOSI output enable
	input  wire logic                 misoIn,                // MISO pin level
	output      logic                 misoOut,               // MISO drive value
	output      logic                 misoOe,                // MISO output enable
	input  wire logic                 ssNIn,                 // Select pin level, active low
	output      logic                 ssNOut,                // Select drive value
	output      logic                 ssNOe                  // Select output enable
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	spi_port_pkg::master_state_type state_q;
	spi_port_pkg::byte_type         shift_q;
	spi_port_pkg::byte_type         shifted;
	spi_port_pkg::byte_type         rxBuf_q;
	spi_port_pkg::byte_type         mRx_q;
	spi_port_pkg::byte_type         mRxNext;
	logic [1:0]                     mSamp_q;
	logic [1:0]                     mLast_q;
	logic [`SPI_PIN_COUNT-1:0]      pinsSync;
	logic [2:0]                     bitCnt_q;
	logic [3:0]                     edgeCnt_q;
	logic                           masterSel_q;
	logic                           sckLevel_q;
	logic                           sckPrev_q;
	logic                           dataOut_q;
	logic                           ssOut_q;
	logic                           tcFlag_q;
	logic                           wcFlag_q;
	logic                           tcArm_q;
	logic                           wcArm_q;
	logic                           enabled;
	logic                           ssLow;
	logic                           sckS;
	logic                           inBit;
	logic                           modeFault;
	logic                           slaveActive;
	logic                           slaveIdle;
	logic                           slaveEdge;
	logic                           masterTick;
	logic                           edgeEv;
	logic                           leadEv;
	logic                           sampleEv;
	logic                           setupEv;
	logic                           busy;
	logic                           writeOk;
	logic                           startMaster;
	logic                           masterDone;
	logic                           slaveDone;
	logic                           dataAccess;

	spi_rate_if rate ();

	function automatic logic outBitOf(input spi_port_pkg::byte_type v, input logic lsbFirst);
		outBitOf = lsbFirst ? v[0] : v[`SPI_BYTE_BITS-1];
	endfunction : outBitOf

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	spi_pin_sync #(
		.N       (`SPI_PIN_COUNT),
		.RST_VAL (`SPI_PIN_RST)
	) uSync (
		.core_clk (core_clk),
		.rst      (rst),
		.pinsIn   ({ssNIn, misoIn, mosiIn, sckIn}),
		.pinsSync (pinsSync)
	);

	spi_rate_gen #(
		.CNT_W (`SPI_RATE_CNT_BITS)
	) uRate (
		.core_clk (core_clk),
		.rst      (rst),
		.rate     (rate.gen)
	);

	assign rate.rateCode = {doubleSpeedBit, rateSelectHigh, rateSelectLow};  // see (RL24)
	assign rate.run      = (state_q == spi_port_pkg::stShift);

	// ----------------------------------------------------------------
	// Role and edge decoding
	// ----------------------------------------------------------------
	assign enabled     = portEnable && !serialPortPowerGate;                  // see (RL1)
	assign ssLow       = !pinsSync[`SPI_PIN_SS];
	assign sckS        = pinsSync[`SPI_PIN_SCK];
	assign modeFault   = enabled && masterSel_q && !dirSs && ssLow;            // see (RL15)
	assign slaveActive = enabled && !masterSel_q && ssLow;                     // see (RL12)
	assign slaveIdle   = !masterSel_q && !ssLow;
	// Edges are taken from the synchronised clock, so phases must last over two cycles
	assign slaveEdge   = slaveActive && (sckS != sckPrev_q);                   // see (RL10)
	assign masterTick  = rate.run && rate.tick;
	assign edgeEv      = masterTick || slaveEdge;
	assign leadEv      = masterSel_q ? (sckLevel_q == clockPolarity) : (sckPrev_q == clockPolarity);
	assign sampleEv    = edgeEv && (leadEv != clockPhase);                     // see (RL25)
	assign setupEv     = edgeEv && (leadEv == clockPhase);
	assign inBit       = masterSel_q ? pinsSync[`SPI_PIN_MISO] : pinsSync[`SPI_PIN_MOSI];  // see (RL7)
	assign shifted     = dataOrderLsbFirst ? {inBit, shift_q[7:1]} : {shift_q[6:0], inBit};
	assign mRxNext     = dataOrderLsbFirst ? {pinsSync[`SPI_PIN_MISO], mRx_q[7:1]}
	                                       : {mRx_q[6:0], pinsSync[`SPI_PIN_MISO]};

	assign masterDone  = masterTick && (edgeCnt_q == `SPI_LAST_EDGE);         // see (RL3)
	assign slaveDone   = slaveEdge && sampleEv && (bitCnt_q == `SPI_LAST_BIT); // see (RL6)

	// The single shift register is the transmit path, so a busy port refuses data
	assign busy        = rate.run || (slaveActive && (bitCnt_q != `SPI_RST_BITCNT));  // see (RL8)
	assign writeOk     = dataWrite && enabled && !busy;                        // see (RL20)
	assign startMaster = writeOk && masterSel_q && !modeFault;                 // see (RL2)
	assign dataAccess  = dataWrite || dataRead;

	// ----------------------------------------------------------------
	// Master clock sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= spi_port_pkg::stIdle;
		end else if (!enabled || modeFault || masterDone) begin
			state_q <= spi_port_pkg::stIdle;                                   // see (RL3)
		end else if (startMaster) begin
			state_q <= spi_port_pkg::stShift;                                  // see (RL2)
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			edgeCnt_q  <= `SPI_RST_EDGECNT;
			sckLevel_q <= `SPI_RST_FLAG;
		end else if (state_q == spi_port_pkg::stIdle || startMaster) begin
			edgeCnt_q  <= `SPI_RST_EDGECNT;
			sckLevel_q <= clockPolarity;
		end else if (masterTick) begin
			edgeCnt_q  <= edgeCnt_q + 4'h1;
			sckLevel_q <= !sckLevel_q;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sckPrev_q <= `SPI_RST_FLAG;
		end else begin
			sckPrev_q <= sckS;
		end
	end

	// ----------------------------------------------------------------
	// Shift register and bit counter
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			shift_q <= `SPI_RST_BYTE;
		end else if (writeOk) begin
			shift_q <= dataWdata;
		end else if (enabled && slaveIdle && (bitCnt_q != `SPI_RST_BITCNT)) begin
			shift_q <= `SPI_RST_BYTE;                                          // see (RL13)
		end else if (sampleEv) begin
			shift_q <= shifted;                                                // see (RL7)
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bitCnt_q <= `SPI_RST_BITCNT;
		end else if (!enabled || slaveIdle || startMaster || modeFault) begin
			bitCnt_q <= `SPI_RST_BITCNT;                                       // see (RL13)
		end else if (sampleEv) begin
			bitCnt_q <= bitCnt_q + 3'h1;
		end
	end

	// Output bit is held in a flop so within a byte it changes only on setup edges
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dataOut_q <= `SPI_RST_FLAG;
		end else if (writeOk) begin
			dataOut_q <= outBitOf(dataWdata, dataOrderLsbFirst);
		end else if (slaveIdle) begin
			dataOut_q <= outBitOf(shift_q, dataOrderLsbFirst);                 // see (RL5)
		end else if (setupEv) begin
			dataOut_q <= outBitOf(shift_q, dataOrderLsbFirst);                 // see (RL25)
		end
	end

	// Synced MISO lags its pin by two cycles, so the master captures two cycles after each sample edge
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mSamp_q <= 2'h0;
			mLast_q <= 2'h0;
		end else begin
			mSamp_q <= {mSamp_q[0], masterTick && sampleEv};
			mLast_q <= {mLast_q[0], masterTick && sampleEv && (edgeCnt_q[3:1] == 3'h7)};
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mRx_q <= `SPI_RST_BYTE;
		end else if (mSamp_q[1]) begin
			mRx_q <= mRxNext;                                                  // see (RL7)
		end
	end

	// Earlier byte is overwritten when software has not read it in time
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rxBuf_q <= `SPI_RST_BYTE;
		end else if (mSamp_q[1] && mLast_q[1]) begin
			rxBuf_q <= mRxNext;                                                // see (RL19)
		end else if (slaveDone) begin
			rxBuf_q <= shifted;                                                // see (RL19)
		end
	end

	// ----------------------------------------------------------------
	// Role bit
	// ----------------------------------------------------------------
	// A hardware clear beats a software set: the select pin is still low
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			masterSel_q <= `SPI_RST_FLAG;
		end else if (modeFault || masterSelectClear) begin
			masterSel_q <= 1'b0;                                               // see (RL15)
		end else if (masterSelectSet) begin
			masterSel_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tcFlag_q <= `SPI_RST_FLAG;
		end else if (masterDone || slaveDone || modeFault) begin
			tcFlag_q <= 1'b1;                                                  // see (RL16)
		end else if ((tcArm_q && dataAccess) || interruptAck) begin
			tcFlag_q <= 1'b0;                                                  // see (RL23)
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wcFlag_q <= `SPI_RST_FLAG;
		end else if (dataWrite && enabled && busy) begin
			wcFlag_q <= 1'b1;                                                  // see (RL22)
		end else if ((tcArm_q || wcArm_q) && dataAccess) begin
			wcFlag_q <= 1'b0;                                                  // see (RL23)
		end
	end

	// An armed complete flag lets the following data access clear both flags; an armed collision flag clears only itself
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tcArm_q <= `SPI_RST_FLAG;
			wcArm_q <= `SPI_RST_FLAG;
		end else if (statusRead) begin
			tcArm_q <= tcFlag_q;
			wcArm_q <= wcFlag_q;
		end else if (dataAccess || interruptAck) begin
			tcArm_q <= 1'b0;
			wcArm_q <= 1'b0;                                                   // see (RL23)
		end
	end

	// ----------------------------------------------------------------
	// Pins
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ssOut_q <= 1'b1;
		end else begin
			ssOut_q <= ssOutValue;                                             // see (RL4)
		end
	end

	assign sckOut  = sckLevel_q;
	assign sckOe   = enabled && masterSel_q && dirSck;                         // see (RL11)
	assign mosiOut = dataOut_q;
	assign mosiOe  = enabled && masterSel_q && dirMosi;                        // see (RL11)
	assign misoOut = dataOut_q;
	assign misoOe  = slaveActive && dirMiso;                                   // see (RL12)
	assign ssNOut  = ssOut_q;
	// Select is a plain output for a master; an enabled slave never drives it
	assign ssNOe   = dirSs && !(enabled && !masterSel_q);                      // see (RL14)

	// ----------------------------------------------------------------
	// Status outputs
	// ----------------------------------------------------------------
	assign dataRdata            = rxBuf_q;
	assign transferCompleteFlag = tcFlag_q;
	assign writeCollisionFlag   = wcFlag_q;
	assign masterSelectBit      = masterSel_q;
	assign transferBusy         = busy;
	assign irq                  = tcFlag_q && portInterruptEnable;            // see (RL26)

endmodule : spi_master_slave_port

// file: src/spi_port_defs.svh
// Constants for the serial port: field positions, reset values and timing counts
`ifndef SPI_PORT_DEFS_SVH
`define SPI_PORT_DEFS_SVH

// ----------------------------------------------------------------
// Byte and counter layout
// ----------------------------------------------------------------
`define SPI_BYTE_BITS      8
`define SPI_LAST_BIT       3'h7
`define SPI_LAST_EDGE      4'hf
`define SPI_RATE_CNT_BITS  7

// ----------------------------------------------------------------
// Synchronised pin positions
// ----------------------------------------------------------------
`define SPI_PIN_COUNT      4
`define SPI_PIN_SCK        0
`define SPI_PIN_MOSI       1
`define SPI_PIN_MISO       2
`define SPI_PIN_SS         3
`define SPI_PIN_RST        4'h8

// ----------------------------------------------------------------
// Half periods of the serial clock, in core clock cycles
// ----------------------------------------------------------------
`define SPI_HALF_DIV2      7'h01
`define SPI_HALF_DIV4      7'h02
`define SPI_HALF_DIV8      7'h04
`define SPI_HALF_DIV16     7'h08
`define SPI_HALF_DIV32     7'h10
`define SPI_HALF_DIV64     7'h20
`define SPI_HALF_DIV128    7'h40

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SPI_RST_BYTE       8'h00
`define SPI_RST_FLAG       1'b0
`define SPI_RST_BITCNT     3'h0
`define SPI_RST_EDGECNT    4'h0

`endif

// file: src/spi_port_pkg.sv
// Types shared by the serial port modules
package spi_port_pkg;

	typedef logic [7:0] byte_type;

	typedef enum logic {
		stIdle,
		stShift
	} master_state_type;

endpackage : spi_port_pkg

// file: src/spi_rate_if.sv
// Link between the port core and its serial clock rate generator
interface spi_rate_if;
	logic [2:0] rateCode;  // {double speed, rate high, rate low}
	logic       run;       // Generator counts while high
	logic       tick;      // One-cycle pulse per half period of the serial clock

	modport gen  (input rateCode, input run, output tick);
	modport core (output rateCode, output run, input tick);
endinterface : spi_rate_if

// file: src/spi_pin_sync.sv
// Two-stage synchronisers for the serial port input pins
`include "spi_port_defs.svh"

module spi_pin_sync #(
	parameter int           N       = `SPI_PIN_COUNT,
	parameter logic [N-1:0] RST_VAL = '0
) (
	input  wire logic         core_clk,  // Core clock
	input  wire logic         rst,       // Asynchronous reset, active high
	input  wire logic [N-1:0] pinsIn,    // Raw pin levels
	output      logic [N-1:0] pinsSync   // Synchronised pin levels
);

	if (N < 1) begin : gCheck
		$error("spi_pin_sync needs at least one pin");
	end

	// ----------------------------------------------------------------
	// One synchroniser per pin; the first stage feeds only the second
	// ----------------------------------------------------------------
	for (genvar i = 0; i < N; i++) begin : gSync
		logic meta_q;
		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				meta_q      <= RST_VAL[i];
				pinsSync[i] <= RST_VAL[i];
			end else begin
				meta_q      <= pinsIn[i];
				pinsSync[i] <= meta_q;
			end
		end
	end

endmodule : spi_pin_sync

// file: src/spi_rate_gen.sv
// Serial clock rate generator: one tick per half period of the serial clock
`include "spi_port_defs.svh"

module spi_rate_gen #(
	parameter int CNT_W = `SPI_RATE_CNT_BITS
) (
	input  wire logic core_clk,  // Core clock
	input  wire logic rst,       // Asynchronous reset, active high
	spi_rate_if.gen   rate       // Rate code in, tick out
);

	if (CNT_W < `SPI_RATE_CNT_BITS) begin : gCheck
		$error("spi_rate_gen counter too narrow for the slowest rate");
	end

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] half;

	// ----------------------------------------------------------------
	// Divider selection
	// ----------------------------------------------------------------
	always_comb begin
		unique case (rate.rateCode)
			3'h0: half = CNT_W'(`SPI_HALF_DIV4);
			3'h1: half = CNT_W'(`SPI_HALF_DIV16);
			3'h2: half = CNT_W'(`SPI_HALF_DIV64);
			3'h3: half = CNT_W'(`SPI_HALF_DIV128);
			3'h4: half = CNT_W'(`SPI_HALF_DIV2);
			3'h5: half = CNT_W'(`SPI_HALF_DIV8);
			3'h6: half = CNT_W'(`SPI_HALF_DIV32);
			3'h7: half = CNT_W'(`SPI_HALF_DIV64);
		endcase
	end

	assign rate.tick = rate.run && (cnt_q == half - CNT_W'(1));

	// Restarting from zero on every run keeps the first half period full length
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (!rate.run || rate.tick) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + CNT_W'(1);
		end
	end

endmodule : spi_rate_gen

// file: tb/spi_port_properties.sv
// Concurrent checks on the serial port's pins, role and flags
module spi_port_properties (
	input wire logic core_clk, rst, serialPortPowerGate, portEnable, portInterruptEnable, // Clock, reset, control
	input wire logic dataWrite, dirSs, ssNIn, transferCompleteFlag, masterSelectBit,   // Strobe, select, status
	input wire logic transferBusy, irq, sckOe, mosiOe, misoOe                            // Status, pin enables
);
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (rst);
	logic on;
	assign on = portEnable && !serialPortPowerGate;
	irqLevel_a: assert property (irq == (transferCompleteFlag & portInterruptEnable)) else $error("irq wrong");
	gateOff_a: assert property (serialPortPowerGate |-> !(sckOe || mosiOe || misoOe)) else $error("gated drive");
	masterMiso_a: assert property (masterSelectBit |-> !misoOe) else $error("miso driven");
	slavePins_a: assert property (on && !masterSelectBit |-> !(sckOe || mosiOe)) else $error("slave drives");
	startShift_a: assert property (on && masterSelectBit && dataWrite && !transferBusy |=> transferBusy)
		else $error("no start");
	doneFlag_a: assert property ($fell(transferBusy) && masterSelectBit |-> ##[0:1] transferCompleteFlag)
		else $error("no done flag");
	// Select passes two sync stages, so the idle check waits four cycles
	slaveIdle_a: assert property ((!masterSelectBit && ssNIn) [*4] |-> !misoOe) else $error("miso on");
	modeFault_a: assert property ((on && masterSelectBit && !dirSs && !ssNIn) [*3] |-> ##[0:2]
		(!masterSelectBit && transferCompleteFlag)) else $error("no role fault");
	cover property ($rose(transferCompleteFlag) && masterSelectBit);
	cover property ($fell(masterSelectBit));
	cover property (transferBusy && !masterSelectBit);
endmodule : spi_port_properties

// file: tb/spi_far_device.sv
// Far-side slave model: mode 0, most significant bit first
module spi_far_device (
	input wire logic       sck,    // Serial clock
	input wire logic       mosi,   // Data from master
	input wire logic       ssN,    // Select, active low
	input wire logic [7:0] txByte, // Reply byte
	output logic           miso,   // Data to master
	output logic     [7:0] rxByte  // Byte received
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sh;
	always @(negedge ssN) begin
		sh = txByte;
		miso = txByte[7];
	end
	always @(posedge sck) if (!ssN) rxByte = {rxByte[6:0], mosi};
	always @(negedge sck) if (!ssN) begin
		sh = sh << 1;
		miso = sh[7];
	end
	// Released line: never leave the last bit showing
	always @(posedge ssN) miso = ~miso;
endmodule : spi_far_device

// file: tb/spi_master_slave_port_tb.sv
// Self-checking bench for the serial port
module spi_master_slave_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = '0, rst = '1, serialPortPowerGate = '0, portEnable = '1, portInterruptEnable = '0;
	logic masterSelectSet = '0, masterSelectClear = '0, interruptAck = '0, dataWrite = '0, dataRead = '0;
	logic statusRead = '0, dirMiso = '0, dirSs = '1, ssOutValue = '1, tbSck = '0, tbMosi = '0, tbSsN = '1;
	logic [2:0] rate = '0;
	spi_port_pkg::byte_type dataWdata = '0, dataRdata, pRx, got;
	logic transferCompleteFlag, writeCollisionFlag, masterSelectBit, transferBusy, irq, sckOut, sckOe;
	logic mosiOut, mosiOe, misoOut, misoOe, ssNOut, ssNOe, misoIn;
	wire logic sckIn = sckOe ? sckOut : tbSck;
	wire logic mosiIn = mosiOe ? mosiOut : tbMosi;
	wire logic ssNIn = ssNOe ? ssNOut : tbSsN;
	wire logic dataOrderLsbFirst = 1'h0, clockPolarity = 1'h0, clockPhase = 1'h0, dirSck = 1'h1, dirMosi = 1'h1;
	wire logic rateSelectHigh = rate[1], rateSelectLow = rate[0], doubleSpeedBit = rate[2];
	int miscompares = 0, n_tests = 0;
	int divs[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
	spi_master_slave_port dut (.*);
	spi_far_device far (.sck(sckIn), .mosi(mosiIn), .ssN(ssNIn), .txByte(~dataWdata), .miso(misoIn), .rxByte(pRx));
	always #2 core_clk = ~core_clk;
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic give_verdict;
		$display("%0d comparisons, %0d mismatches", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict
	task automatic strobe(ref logic s);
		s = '1;
		@(negedge core_clk);
		s = '0;
	endtask : strobe
	// Mode 0 frame as an outside master; six-cycle phases outlast pin sync
	task automatic sbyte(input logic [7:0] d, input int nb);
		tbSsN = '0;
		for (int i = 7; i > 7 - nb; i--) begin
			tbMosi = d[i];
			repeat (6) @(negedge core_clk);
			got[i] = misoOe ? misoOut : 1'hx;
			tbSck = '1;
			repeat (6) @(negedge core_clk);
			tbSck = '0;
		end
		repeat (6) @(negedge core_clk);
		tbSsN = '1;
		repeat (6) @(negedge core_clk);
	endtask : sbyte
	task automatic t_slave;
		dirMiso = '1;
		sbyte(8'hff, 3);
		chk(transferCompleteFlag, 1'h0);
		dataWdata = 8'h96;
		strobe(dataWrite);
		sbyte(8'h5a, 8);
		chk(got, 8'h96);
		chk({dataRdata, transferCompleteFlag, irq}, {8'h5a, 2'h3});
		dataWdata = 8'hc3;
		strobe(dataWrite);
		sbyte(8'h0f, 8);
		chk(got, 8'hc3);
		chk(dataRdata, 8'h0f);
		strobe(statusRead);
		strobe(dataRead);
		chk(transferCompleteFlag, 1'h0);
		$display("slave test done");
	endtask : t_slave
	task automatic t_master(input int k);
		int n;
		logic [7:0] e;
		e = 8'h30 + 8'(k);
		rate = k[2:0];
		portInterruptEnable = k[0];
		dataWdata = e;
		ssOutValue = '0;
		repeat (2) @(negedge core_clk);
		strobe(dataWrite);
		dataWdata = 8'hff;
		@(negedge core_clk);
		strobe(dataWrite);
		for (n = 2; transferBusy === 1'h1 && n < 1100; n++)
			@(negedge core_clk);
		chk(n >= 8 * divs[k] - 1 && n <= 8 * divs[k] + 1, 1'h1);
		if (n == 1100)
			give_verdict();
		@(negedge core_clk);
		chk({writeCollisionFlag, transferCompleteFlag, irq}, {2'h3, k[0]});
		chk(pRx, e);
		chk(dataRdata, ~e);
		ssOutValue = '1;
		strobe(statusRead);
		strobe(dataRead);
		chk({transferCompleteFlag, writeCollisionFlag}, 2'h0);
		$display("master test done, rate code %0d", k);
	endtask : t_master
	task automatic t_fault;
		dirSs = '0;
		tbSsN = '0;
		repeat (5) @(negedge core_clk);
		chk({masterSelectBit, sckOe, transferCompleteFlag}, 3'h1);
		strobe(interruptAck);
		chk(transferCompleteFlag, 1'h0);
		tbSsN = '1;
		repeat (3) @(negedge core_clk);
		strobe(masterSelectSet);
		serialPortPowerGate = '1;
		strobe(dataWrite);
		chk({masterSelectBit, transferBusy, sckOe}, 3'h4);
		$display("role fault test done");
	endtask : t_fault
	initial begin
		repeat (6) @(negedge core_clk);
		rst = '0;
		portInterruptEnable = '1;
		t_slave();
		strobe(masterSelectSet);
		for (int k = 0; k < 8; k++)
			t_master(k);
		t_fault();
		give_verdict();
	end
endmodule : spi_master_slave_port_tb
bind spi_master_slave_port spi_port_properties props (.*);
